// [dv/sfr_link_sva.sv]
// link and flag assertions for the soft reset pair
`timescale 1ns/1ps
`default_nettype none
module sfr_link_sva (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic armed_out,
  input wire logic recovering_out,
  input wire logic abort_out,
  input wire logic write_enable_latch_out,
  input wire logic write_ready_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  a_exec_needs_arm: assert property (abort_out |-> $past(armed_out) || $past(armed_out, 2))
    else $error("abort without arming");
  a_arm_after_frame: assert property ($rose(armed_out) |-> cs_n && $past(cs_n, 2))
    else $error("armed inside a frame");
  a_abort_clears: assert property (abort_out |-> ##[0:2] !write_enable_latch_out && !armed_out)
    else $error("flags kept after reset");
  a_abort_pulse: assert property (abort_out |=> !abort_out)
    else $error("abort longer than one cycle");
  a_abort_recovers: assert property (abort_out |-> ##[0:2] recovering_out)
    else $error("no recovery after reset");
  a_recov_no_arm: assert property (recovering_out |-> !$rose(armed_out))
    else $error("armed during recovery");
  a_write_lockout: assert property (!write_ready_out |-> !$rose(write_enable_latch_out))
    else $error("write enabled too early");
  a_clk_idle_low: assert property ($fell(cs_n) |-> !sclk)
    else $error("clock high at frame start");
  a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data moved while clock high");
  c_abort: cover property (abort_out);
  c_arm: cover property ($rose(armed_out));
  c_wel: cover property ($rose(write_enable_latch_out));
endmodule
`default_nettype wire

// [dv/tb.sv]
// bench: host and device joined, raw link for bad frames
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) tests_run++; if ((a) !== (e)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end
module tb;
  import sfr_pkg::*;
  localparam int RST = 300;
  localparam int PUW = 600;
  logic ref_clk_in = 0, nrst_in = 0, req_valid = 0, rdpar_we = 0, busy = 0;
  logic ready, done, write_enable_latch, suspend_flag, armed, recov, wready, abort, armed2, recov2;
  sfr_byte_t op = 0, rdpar = 0, rdpar_o;
  logic [2:0] wrap = 0, wrap_o;
  logic [31:0] seed = 32'h0000_dbc5;
  int mismatches = 0, tests_run = 0, cyc = 0, t_rst = -100000;
  int m_arm = 0, m_wel = 0, m_sus = 0, m_par = 0, m_wrap = 0;
  sfr_byte_t ops[6] = '{SFR_OP_ARM, SFR_OP_EXEC, SFR_OP_WREN, SFR_OP_WRDI, SFR_OP_SUSP, SFR_OP_RESM};
  sfr_link_if link();
  sfr_link_if link2();
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) cyc++;
  sfr_host #(.RST_CYC(1), .PUW_CYC(1)) sfr_host_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .link(link.host), .req_valid_in(req_valid), .req_op_in(op), .req_ready_out(ready),
    .done_out(done));
  sfr_dev #(.RST_CYC(RST), .PUW_CYC(PUW)) sfr_dev_inst (.ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in), .link(link.dev), .rdpar_we_in(rdpar_we), .rdpar_in(rdpar), .wrap_in(wrap),
    .busy_in(busy), .write_enable_latch_out(write_enable_latch), .suspend_flag_out(suspend_flag),
    .read_parameter_bits_out(rdpar_o), .wrap_setting_bits_out(wrap_o), .armed_out(armed),
    .recovering_out(recov), .write_ready_out(wready), .abort_out(abort));
  sfr_dev #(.RST_CYC(RST), .PUW_CYC(PUW)) sfr_dev_inst2 (.ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in), .link(link2.dev), .rdpar_we_in(rdpar_we), .rdpar_in(rdpar), .wrap_in(wrap),
    .busy_in(busy), .write_enable_latch_out(), .suspend_flag_out(), .read_parameter_bits_out(),
    .wrap_setting_bits_out(), .armed_out(armed2), .recovering_out(recov2),
    .write_ready_out(), .abort_out());
  sfr_link_sva sfr_link_sva_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .armed_out(armed),
    .recovering_out(recov), .abort_out(abort), .write_enable_latch_out(write_enable_latch),
    .write_ready_out(wready));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic apply(input sfr_byte_t o);
    if (cyc - t_rst < RST) return;
    if (o == SFR_OP_EXEC && m_arm) begin
      {m_arm, m_wel, m_sus, m_par, m_wrap} = 0;
      t_rst = cyc;
    end else begin
      m_arm = (o == SFR_OP_ARM);
      if (o == SFR_OP_WREN && cyc >= PUW) m_wel = 1;
      if (o == SFR_OP_WRDI) m_wel = 0;
      if (o == SFR_OP_SUSP && busy) m_sus = 1;
      if (o == SFR_OP_RESM) m_sus = 0;
    end
  endtask
  task automatic send(input sfr_byte_t o);
    int n = 0;
    @(negedge ref_clk_in);
    op = o;
    req_valid = 1;
    #1;
    while (!ready && n++ < 2000) @(negedge ref_clk_in) #1;
    if (!ready) mismatches++;
    @(negedge ref_clk_in);
    req_valid = 0;
    n = 0;
    while (done !== 1'b1 && n++ < 200) @(negedge ref_clk_in);
    if (done !== 1'b1) mismatches++;
    apply(o);
    repeat (2) @(negedge ref_clk_in);
    `CHK("armed", m_arm[0], armed)
    `CHK("wel", m_wel[0], write_enable_latch)
    `CHK("sus", m_sus[0], suspend_flag)
    `CHK("par", m_par[7:0], rdpar_o)
    `CHK("wrap", m_wrap[2:0], wrap_o)
    `CHK("recov", cyc - t_rst < RST, recov)
  endtask
  task automatic raw(input int n, input sfr_byte_t b, input logic e);
    link2.cs_n = 0;
    for (int i = 0; i < n; i++) begin
      link2.mosi = b[7 - i % 8];
      repeat (4) @(negedge ref_clk_in);
      link2.sclk = 1;
      repeat (4) @(negedge ref_clk_in);
      link2.sclk = 0;
    end
    repeat (4) @(negedge ref_clk_in);
    link2.cs_n = 1;
    link2.mosi = ~link2.mosi;
    repeat (8) @(negedge ref_clk_in);
    `CHK("armed2", e, armed2)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    link2.cs_n = 1;
    link2.sclk = 0;
    link2.mosi = 0;
    repeat (4) @(negedge ref_clk_in);
    nrst_in = 1;
    send(SFR_OP_WREN);
    `CHK("wready", 1'b0, wready)
    while (cyc < PUW + 20) @(negedge ref_clk_in);
    `CHK("wready", 1'b1, wready)
    $display("lockout test done");
    seed = xs(seed);
    rdpar = seed[7:0];
    wrap = seed[10:8];
    busy = 1;
    rdpar_we = 1;
    @(negedge ref_clk_in);
    rdpar_we = 0;
    m_par = rdpar;
    m_wrap = wrap;
    foreach (ops[i]) send(ops[(i + 2) % 6]);
    `CHK("sus_pre", 1'b0, suspend_flag)
    send(SFR_OP_ARM);
    send(SFR_OP_WREN);
    send(SFR_OP_EXEC);
    send(SFR_OP_SUSP);
    send(SFR_OP_ARM);
    send(SFR_OP_ARM);
    send(SFR_OP_EXEC);
    send(SFR_OP_ARM);
    send(SFR_OP_WREN);
    $display("reset pair test done");
    for (int k = 0; k < 30; k++) begin
      if (cyc - t_rst < RST + 10) repeat (RST) @(negedge ref_clk_in);
      seed = xs(seed);
      busy = seed[8];
      send(ops[seed[15:0] % 6]);
    end
    $display("random test done");
    raw(7, SFR_OP_ARM, 1'b0);
    raw(9, SFR_OP_ARM, 1'b0);
    raw(8, SFR_OP_ARM, 1'b1);
    raw(8, SFR_OP_EXEC, 1'b0);
    `CHK("recov2", 1'b1, recov2)
    $display("frame length test done");
    end_sim();
  end
  initial begin
    #600000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire

// [pkg/sfr_link_if.sv]
// spi link between host and flash soft reset logic
`timescale 1ns/1ps
`default_nettype none
interface sfr_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  modport host (output sclk, output cs_n, output mosi);
  modport dev (input sclk, input cs_n, input mosi);
endinterface
`default_nettype wire

// [pkg/sfr_pkg.sv]
// shared constants for the serial flash soft reset link
package sfr_pkg;
  localparam int unsigned SFR_CLK_MHZ = 100;
  localparam logic [7:0] SFR_OP_ARM = 8'h66;
  localparam logic [7:0] SFR_OP_EXEC = 8'h99;
  localparam logic [7:0] SFR_OP_WREN = 8'h06;
  localparam logic [7:0] SFR_OP_WRDI = 8'h04;
  localparam logic [7:0] SFR_OP_SUSP = 8'h75;
  localparam logic [7:0] SFR_OP_RESM = 8'h7a;
  localparam int unsigned SFR_RST_US = 30;
  localparam int unsigned SFR_RST_CYC = SFR_RST_US * SFR_CLK_MHZ;
  localparam int unsigned SFR_PUW_MS = 5;
  localparam int unsigned SFR_PUW_CYC = SFR_PUW_MS * 1000 * SFR_CLK_MHZ;
  localparam int unsigned SFR_BYTE_BITS = 8;
  localparam int unsigned SFR_HALF_DIV = 4;
  localparam logic [7:0] SFR_RDPAR_RST = 8'h00;
  localparam logic [2:0] SFR_WRAP_RST = 3'h0;
  typedef logic [7:0] sfr_byte_t;
endpackage

// [rtl/sfr_dev.sv]
// flash-side instruction decoder with soft reset and write lockout
`timescale 1ns/1ps
`default_nettype none
module sfr_dev #(
  parameter int unsigned RST_CYC = sfr_pkg::SFR_RST_CYC,
  parameter int unsigned PUW_CYC = sfr_pkg::SFR_PUW_CYC
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  sfr_link_if.dev link,
  input wire logic rdpar_we_in,
  input wire sfr_pkg::sfr_byte_t rdpar_in,
  input wire logic [2:0] wrap_in,
  input wire logic busy_in,
  output logic write_enable_latch_out,
  output logic suspend_flag_out,
  output sfr_pkg::sfr_byte_t read_parameter_bits_out,
  output logic [2:0] wrap_setting_bits_out,
  output logic armed_out,
  output logic recovering_out,
  output logic write_ready_out,
  output logic abort_out
);
  import sfr_pkg::*;
  ////////////////////////////////////////////////////////////////////
  // link domain: shift in frame bits
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  sfr_byte_t byte_r;
  logic tog_r;
  wire logic frame_rst_n = nrst_in & ~link.cs_n;
  wire logic [3:0] cnt_nxt = (cnt_r == 4'h9) ? cnt_r : cnt_r + 4'h1;
  wire logic [7:0] sh_nxt = {sh_r[6:0], link.mosi};
  wire logic frame_full = (cnt_r == 4'(SFR_BYTE_BITS));

  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sh_r <= 8'h00;
    end else begin
      sh_r <= sh_nxt;
    end
  end
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  // capture on cs rise: exact eight bits only
  always_ff @(posedge link.cs_n or negedge nrst_in) begin
    if (!nrst_in) begin
      byte_r <= 8'h00;
    end else if (frame_full) begin
      byte_r <= sh_r;
    end
  end
  always_ff @(posedge link.cs_n or negedge nrst_in) begin
    if (!nrst_in) begin
      tog_r <= 1'b0;
    end else if (frame_full) begin
      tog_r <= ~tog_r;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // crossing into ref_clk domain
  logic [2:0] tog_s_r;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tog_s_r <= 3'h0;
    end else begin
      tog_s_r <= {tog_s_r[1:0], tog_r};
    end
  end
  wire logic frame_ev = tog_s_r[2] ^ tog_s_r[1];
  wire sfr_byte_t op = byte_r; // stable for many ref cycles after toggle
  ////////////////////////////////////////////////////////////////////
  // command decode
  logic armed_r;
  logic [31:0] rst_cnt_r;
  logic [31:0] puw_cnt_r;
  logic wel_r;
  logic sus_r;
  sfr_byte_t rdpar_r;
  logic [2:0] wrap_r;
  logic abort_r;
  wire logic recov = (rst_cnt_r != 32'h0000_0000);
  wire logic puw_done = (puw_cnt_r == 32'h0000_0000);
  wire logic cmd_ok = frame_ev & ~recov;
  wire logic is_exec = cmd_ok & armed_r & (op == SFR_OP_EXEC);
  wire logic is_write = (op == SFR_OP_WREN);
  wire logic write_ok = cmd_ok & is_write & puw_done;
  // decoded instruction codes
  wire logic is_wrdi = (op == SFR_OP_WRDI);
  wire logic is_susp = (op == SFR_OP_SUSP);
  wire logic is_resm = (op == SFR_OP_RESM);
  wire logic wel_clr = cmd_ok & is_wrdi;
  wire logic sus_set = cmd_ok & is_susp & busy_in;
  wire logic sus_clr = cmd_ok & is_resm;
  wire logic par_ld = rdpar_we_in & ~recov;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      armed_r <= 1'b0;
    end else if (cmd_ok) begin
      armed_r <= (op == SFR_OP_ARM) & ~is_exec;
    end
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_cnt_r <= 32'h0000_0000;
      puw_cnt_r <= 32'(PUW_CYC);
    end else begin
      if (is_exec) begin
        rst_cnt_r <= 32'(RST_CYC);
      end else if (recov) begin
        rst_cnt_r <= rst_cnt_r - 32'h0000_0001;
      end
      if (!puw_done) begin
        puw_cnt_r <= puw_cnt_r - 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // abort pulse set by an accepted reset; volatile flags cleared by it
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= is_exec;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wel_r <= 1'b0;
    end else if (is_exec) begin
      wel_r <= 1'b0;
    end else if (write_ok) begin
      wel_r <= 1'b1;
    end else if (wel_clr) begin
      wel_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sus_r <= 1'b0;
    end else if (is_exec) begin
      sus_r <= 1'b0;
    end else if (sus_set) begin
      sus_r <= 1'b1;
    end else if (sus_clr) begin
      sus_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdpar_r <= SFR_RDPAR_RST;
      wrap_r <= SFR_WRAP_RST;
    end else if (is_exec) begin
      rdpar_r <= SFR_RDPAR_RST;
      wrap_r <= SFR_WRAP_RST;
    end else if (par_ld) begin
      rdpar_r <= rdpar_in;
      wrap_r <= wrap_in;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registered status outputs
  logic recov_r;
  logic ready_r;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      recov_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      recov_r <= recov;
      ready_r <= puw_done;
    end
  end
  assign write_enable_latch_out = wel_r;
  assign suspend_flag_out = sus_r;
  assign read_parameter_bits_out = rdpar_r;
  assign wrap_setting_bits_out = wrap_r;
  assign armed_out = armed_r;
  assign recovering_out = recov_r;
  assign write_ready_out = ready_r;
  assign abort_out = abort_r;
endmodule
`default_nettype wire

// [rtl/sfr_host.sv]
// host-side spi sender of single-byte instructions
`timescale 1ns/1ps
`default_nettype none
module sfr_host #(
  parameter int unsigned RST_CYC = sfr_pkg::SFR_RST_CYC,
  parameter int unsigned PUW_CYC = sfr_pkg::SFR_PUW_CYC
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  sfr_link_if.host link,
  input wire logic req_valid_in,
  input wire sfr_pkg::sfr_byte_t req_op_in,
  output logic req_ready_out,
  output logic done_out
);
  import sfr_pkg::*;
  typedef enum logic [1:0] {SFH_IDLE, SFH_SHIFT, SFH_END, SFH_WAIT} sfh_state_e;
  sfh_state_e st_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic [2:0] div_r;
  logic sclk_r;
  logic cs_n_r;
  logic done_r;
  logic [31:0] hold_r;
  logic [31:0] puw_r;
  wire logic is_wr = (req_op_in == SFR_OP_WREN);
  wire logic can_go = (hold_r == 32'h0000_0000) & (~is_wr | (puw_r == 32'h0000_0000));
  wire logic take = (st_r == SFH_IDLE) & req_valid_in & can_go;
  wire logic tick = (div_r == 3'(SFR_HALF_DIV - 1));
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= SFH_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      div_r <= 3'h0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      div_r <= tick ? 3'h0 : div_r + 3'h1;
      case (st_r)
        SFH_IDLE: begin
          div_r <= 3'h0;
          if (take) begin
            sh_r <= req_op_in;
            bit_r <= 4'h0;
            cs_n_r <= 1'b0;
            st_r <= SFH_SHIFT;
          end
        end
        SFH_SHIFT: begin
          if (tick) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              sh_r <= {sh_r[6:0], 1'b0};
              if (bit_r == 4'(SFR_BYTE_BITS - 1)) begin
                st_r <= SFH_END;
              end
              bit_r <= bit_r + 4'h1;
            end
          end
        end
        SFH_END: begin
          if (tick) begin
            cs_n_r <= 1'b1;
            st_r <= SFH_WAIT;
          end
        end
        SFH_WAIT: begin
          if (tick) begin
            done_r <= 1'b1;
            st_r <= SFH_IDLE;
          end
        end
        default: st_r <= SFH_IDLE;
      endcase
    end
  end
  // hold-off counted from accepting the execute byte; power-up write delay
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_r <= 32'h0000_0000;
      puw_r <= 32'(PUW_CYC);
    end else begin
      if (take & (req_op_in == SFR_OP_EXEC)) begin
        hold_r <= 32'(RST_CYC) + 32'h0000_0040;
      end else if (hold_r != 32'h0000_0000) begin
        hold_r <= hold_r - 32'h0000_0001;
      end
      if (puw_r != 32'h0000_0000) begin
        puw_r <= puw_r - 32'h0000_0001;
      end
    end
  end
  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = sh_r[7];
  assign req_ready_out = take;
  assign done_out = done_r;
endmodule
`default_nettype wire
